// ---- imu_fmt_defs.svh ----
// Constants of the output word formatter: widths, positions, timing and reset values
`ifndef IMU_FMT_DEFS_SVH
`define IMU_FMT_DEFS_SVH

// ==========================================================
// Word widths
`define AXES 3
`define WORD_W 24
`define TEMP_W 16
`define SUM_W 32
`define CNT_W 8
`define CNT_MAX 8'hff

// ==========================================================
// Timing
`define CLK_PERIOD_NS 4
`define US_NS 1000
`define CYC_PER_US ((`US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_W 8

// ==========================================================
// Saturation and range limits
`define US_MAX 24'h7fffff
`define PPS_ONE 24'h400000

// ==========================================================
// Record layout, most significant byte sent first
`define FIFO_DEPTH 16
`define REC_W 145
`define REC_TFLAG 144
`define REC_ACC_LSB 72
`define REC_PPS_LSB 48
`define REC_TEMP_LSB 0

// ==========================================================
// Reset values
`define WORD_RST 24'h000000
`define SUM_RST 32'h00000000
`define CNT_RST 8'h00
`define DIV_RST 8'h00

`endif

// ---- imu_fmt_pkg.sv ----
// Types of the output word formatter
`include "imu_fmt_defs.svh"

package imu_fmt_pkg;

    // ==========================================================
    // Modes
    typedef enum logic [1:0] {
        ACC_OUT = 2'b00,
        INC_VEL = 2'b01,
        AVG_ACC = 2'b10,
        INT_VEL = 2'b11
    } accel_mode_type;

    typedef enum logic [1:0] {
        PPS_SINCE_LOW = 2'b00,
        PPS_SINCE_HIGH = 2'b01,
        PPS_FILTERED = 2'b10
    } pps_mode_type;

    // ==========================================================
    // Formatter state
    typedef struct packed {
        logic [`AXES-1:0][`WORD_W-1:0] acc;
        logic [`AXES-1:0][`WORD_W-1:0] inc;
        logic [`AXES-1:0][`WORD_W-1:0] ivel;
        logic [`AXES-1:0][`WORD_W-1:0] avg;
        logic [`AXES-1:0][`SUM_W-1:0] sum;
        logic [`CNT_W-1:0] cnt;
        logic pps_prev;
        logic [1:0][`DIV_W-1:0] div;
        logic [1:0][`WORD_W-1:0] us;
    } fmt_state_type;

endpackage : imu_fmt_pkg

// ---- stream_if.sv ----
// Valid/ready stream between formatter and record buffer
`timescale 1ns/1ns

interface stream_if #(parameter int WIDTH = 8) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ---- word_fifo.sv ----
// Record buffer with valid and ready on both sides
`timescale 1ns/1ns

module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Fill and drain sides
    stream_if.snk wr,
    stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_type;

    fifo_state_type s_q;
    fifo_state_type s_d;
    logic push;
    logic pop;

    // ==========================================================
    // Handshakes
    assign wr.ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign rd.valid = (s_q.cnt != '0);
    assign rd.data = s_q.mem[s_q.rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = wr.data;
            s_d.wp = (s_q.wp == (AW)'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == (AW)'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : word_fifo

// ---- imu_output_word_formatter.sv ----
// Accelerometer, pulse-per-second and temperature output word formatter
`timescale 1ns/1ns
`include "imu_fmt_defs.svh"

module imu_output_word_formatter
    import imu_fmt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Compensated samples
    input wire logic sample_valid,
    input wire logic [`AXES-1:0][`WORD_W-1:0] acceleration_word_in,
    input wire logic [`AXES-1:0][`WORD_W-1:0] velocity_increment_word_in,
    input wire logic [`AXES-1:0][`TEMP_W-1:0] temp_in,
    // Pulse-per-second sources
    input wire logic pps_level,
    input wire logic [`WORD_W-1:0] pps_filtered,
    // Output unit selection
    input wire accel_mode_type accel_mode,
    input wire pps_mode_type pps_mode,
    input wire logic temp_enable,
    // Transmission request from the assembler
    input wire logic tx_request,
    output logic tx_ready,
    // Record stream to the assembler
    output logic rec_valid,
    output logic [`REC_W-1:0] rec_data,
    input wire logic rec_ready
);

    fmt_state_type s_q;
    fmt_state_type s_d;
    logic tx_take;
    logic [`REC_W-1:0] record;
    logic [`AXES-1:0][`WORD_W-1:0] avg_now;
    logic [`AXES-1:0][`WORD_W-1:0] out_word;
    logic [`WORD_W-1:0] pps_word;

    stream_if #(.WIDTH(`REC_W)) wr_link ();
    stream_if #(.WIDTH(`REC_W)) rd_link ();

    // ==========================================================
    // Record buffer
    word_fifo #(
        .WIDTH(`REC_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(wr_link),
        .rd(rd_link)
    );

    assign wr_link.valid = tx_request;
    assign wr_link.data = record;
    assign tx_ready = wr_link.ready;
    assign tx_take = tx_request && wr_link.ready;
    assign rec_valid = rd_link.valid;
    assign rec_data = rd_link.data;
    assign rd_link.ready = rec_ready;

    // ==========================================================
    // Sample capture, averaging and integration
    always_comb begin
        logic signed [`SUM_W-1:0] quot;
        logic signed [`SUM_W-1:0] div_by;
        quot = '0;
        div_by = '0;
        s_d = s_q;
        avg_now = s_q.avg;
        if (sample_valid) begin
            s_d.acc = acceleration_word_in;
            s_d.inc = velocity_increment_word_in;
            if (s_q.cnt != `CNT_MAX) begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
        for (int a = 0; a < `AXES; a++) begin
            if (sample_valid) begin
                // 24-bit sum wraps by itself
                s_d.ivel[a] = s_q.ivel[a] + velocity_increment_word_in[a];
                if (s_q.cnt != `CNT_MAX) begin
                    s_d.sum[a] = s_q.sum[a]
                        + {{(`SUM_W-`WORD_W){acceleration_word_in[a][`WORD_W-1]}},
                           acceleration_word_in[a]};
                end
            end
            // Mean of the first 255 samples since last send
            div_by = $signed({{(`SUM_W-`CNT_W){1'b0}}, s_d.cnt});
            if (s_d.cnt != `CNT_RST) begin
                quot = $signed(s_d.sum[a]) / div_by;
                avg_now[a] = quot[`WORD_W-1:0];
            end
        end
        if (tx_take) begin
            s_d.avg = avg_now;
            s_d.cnt = `CNT_RST;
            for (int a = 0; a < `AXES; a++) begin
                s_d.sum[a] = `SUM_RST;
            end
        end

        // ======================================================
        // Microsecond time since each pulse level
        s_d.pps_prev = pps_level;
        for (int l = 0; l < 2; l++) begin
            if ((pps_level == l[0]) && (s_q.pps_prev != l[0])) begin
                s_d.div[l] = `DIV_RST;
                s_d.us[l] = `WORD_RST;
            end else if (s_q.div[l] == (`DIV_W)'(`CYC_PER_US - 1)) begin
                s_d.div[l] = `DIV_RST;
                if (s_q.us[l] != `US_MAX) begin
                    s_d.us[l] = s_q.us[l] + 1'b1;
                end
            end else begin
                s_d.div[l] = s_q.div[l] + 1'b1;
            end
        end
    end

    // ==========================================================
    // Output word selection
    always_comb begin
        for (int a = 0; a < `AXES; a++) begin
            case (accel_mode)
                ACC_OUT: out_word[a] = s_d.acc[a];
                INC_VEL: out_word[a] = s_d.inc[a];
                AVG_ACC: out_word[a] = avg_now[a];
                INT_VEL: out_word[a] = s_d.ivel[a];
                default: out_word[a] = `WORD_RST;
            endcase
        end
        case (pps_mode)
            PPS_SINCE_LOW: pps_word = s_d.us[0];
            PPS_SINCE_HIGH: pps_word = s_d.us[1];
            PPS_FILTERED: pps_word = (pps_filtered > `PPS_ONE) ? `PPS_ONE : pps_filtered;
            default: pps_word = `WORD_RST;
        endcase
    end

    // ==========================================================
    // Record packing, MSB first
    always_comb begin
        record = '0;
        record[`REC_TFLAG] = temp_enable;
        record[`REC_PPS_LSB +: `WORD_W] = pps_word;
        for (int a = 0; a < `AXES; a++) begin
            record[`REC_ACC_LSB + (`AXES-1-a)*`WORD_W +: `WORD_W] = out_word[a];
            if (temp_enable) begin
                record[`REC_TEMP_LSB + (`AXES-1-a)*`TEMP_W +: `TEMP_W] = temp_in[a];
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : imu_output_word_formatter

// ---- imu_fmt_props.sv ----
// Port checker of the output word formatter
`timescale 1ns/1ns
`include "imu_fmt_defs.svh"

module imu_fmt_props
    import imu_fmt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Watched ports
    input wire logic sample_valid,
    input wire logic [`AXES-1:0][`WORD_W-1:0] acceleration_word_in,
    input wire logic [`AXES-1:0][`TEMP_W-1:0] temp_in,
    input wire logic [`WORD_W-1:0] pps_filtered,
    input wire accel_mode_type accel_mode,
    input wire pps_mode_type pps_mode,
    input wire logic temp_enable,
    input wire logic tx_request,
    input wire logic tx_ready,
    input wire logic rec_valid,
    input wire logic [`REC_W-1:0] rec_data,
    input wire logic rec_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ==========
    // Steps
    sequence take_s;
        tx_request && tx_ready && !rec_valid;
    endsequence
    sequence stall_s;
        rec_valid && !rec_ready;
    endsequence

    take_latency_a: assert property (take_s |=> rec_valid)
        else $error("record late");
    rec_hold_a: assert property (stall_s |=> rec_valid && $stable(rec_data))
        else $error("record changed while stalled");
    empty_ready_a: assert property (!rec_valid |-> tx_ready)
        else $error("refused while empty");
    temp_flag_a: assert property (take_s |=> rec_data[144] == $past(temp_enable))
        else $error("temperature flag wrong");
    temp_zero_a: assert property (rec_valid && !rec_data[144] |-> rec_data[47:0] == 48'h0)
        else $error("temperatures not zero");
    temp_copy_a: assert property (take_s ##0 temp_enable |=> rec_data[47:32] == $past(temp_in[0]))
        else $error("temperature word wrong");
    pps_clamp_a: assert property (take_s ##0 pps_mode == PPS_FILTERED |=> rec_data[71:48] ==
        ($past(pps_filtered) > `PPS_ONE ? `PPS_ONE : $past(pps_filtered)))
        else $error("filtered word wrong");
    acc_word_a: assert property (take_s ##0 sample_valid && accel_mode == ACC_OUT
        |=> rec_data[143:120] == $past(acceleration_word_in[0]))
        else $error("acceleration word wrong");
endmodule : imu_fmt_props

bind imu_output_word_formatter imu_fmt_props props (.clk_sys, .rst, .sample_valid,
    .acceleration_word_in, .temp_in, .pps_filtered, .accel_mode, .pps_mode, .temp_enable,
    .tx_request, .tx_ready, .rec_valid, .rec_data, .rec_ready);

// ---- record_sink.sv ----
// Drain-side model that pops records and keeps them in order
`timescale 1ns/1ns
`include "imu_fmt_defs.svh"

module record_sink (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Record stream
    input wire logic rec_valid,
    input wire logic [`REC_W-1:0] rec_data,
    output logic rec_ready,
    // Stall control
    input wire logic hold
);
    logic [`REC_W-1:0] got[$];

    assign rec_ready = !hold;
    always @(posedge clk_sys) begin
        if (!rst && rec_valid && rec_ready) begin
            got.push_back(rec_data);
        end
    end
endmodule : record_sink

// ---- imu_output_word_formatter_test.sv ----
// Self-checking bench of the output word formatter
`timescale 1ns/1ns
`include "imu_fmt_defs.svh"

module imu_output_word_formatter_test
    import imu_fmt_pkg::*;
();
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b0, pps_level = 1'b0, temp_enable = 1'b0, tx_request = 1'b0;
    logic hold = 1'b0;
    logic [`AXES-1:0][`WORD_W-1:0] acceleration_word_in = '0, velocity_increment_word_in = '0;
    logic [`AXES-1:0][`TEMP_W-1:0] temp_in = '0;
    logic [`WORD_W-1:0] pps_filtered = '0;
    accel_mode_type accel_mode = ACC_OUT;
    pps_mode_type pps_mode = PPS_FILTERED;
    logic tx_ready, rec_valid, rec_ready;
    logic [`REC_W-1:0] rec_data, r;
    int bad_count = 0, n_compared = 0;

    always #2 clk_sys = ~clk_sys;

    imu_output_word_formatter uut (.clk_sys, .rst, .sample_valid, .acceleration_word_in,
        .velocity_increment_word_in, .temp_in, .pps_level, .pps_filtered, .accel_mode,
        .pps_mode, .temp_enable, .tx_request, .tx_ready, .rec_valid, .rec_data, .rec_ready);
    record_sink sink (.clk_sys, .rst, .rec_valid, .rec_data, .rec_ready, .hold);

    // ==========
    // Shared tasks
    task automatic check(input logic [`REC_W-1:0] seen, input logic [`REC_W-1:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic test_done();
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task automatic do_reset();
        rst = 1'b1;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
    endtask : do_reset

    task automatic sample(input logic [`WORD_W-1:0] a, input logic [`WORD_W-1:0] v);
        @(negedge clk_sys);
        acceleration_word_in = {3{a}};
        velocity_increment_word_in = {3{v}};
        sample_valid = 1'b1;
        @(negedge clk_sys);
        sample_valid = 1'b0;
    endtask : sample

    task automatic take(input logic sv);
        sink.got.delete();
        @(negedge clk_sys);
        tx_request = 1'b1;
        sample_valid = sv;
        @(negedge clk_sys);
        tx_request = 1'b0;
        sample_valid = 1'b0;
        for (int i = 0; i < 20 && sink.got.size() == 0; i++) @(negedge clk_sys);
        r = sink.got.size() > 0 ? sink.got[0] : 'x;
    endtask : take

    // ==========
    // Scenarios
    task automatic t_acc();
        acceleration_word_in = {3{24'h080000}};
        pps_filtered = 24'h500000;
        temp_enable = 1'b1;
        temp_in = {16'h0100, 16'hff00, 16'h1980};
        take(1'b1);
        check(r, {1'b1, {3{24'h080000}}, 24'h400000, 48'h1980ff000100});
        pps_filtered = 24'h400000;
        temp_enable = 1'b0;
        take(1'b0);
        check(r, {1'b0, {3{24'h080000}}, 24'h400000, 48'h0});
    endtask : t_acc

    task automatic t_avg();
        accel_mode = AVG_ACC;
        sample(24'h000010, 24'h0);
        sample(24'h000020, 24'h0);
        acceleration_word_in = {3{24'hfffffd}};
        take(1'b1);
        check(r[143:72], {3{24'h00000f}});
        take(1'b0);
        check(r[143:72], {3{24'h00000f}});
        sample(24'hfffffb, 24'h0);
        sample(24'hfffffe, 24'h0);
        take(1'b0);
        check(r[143:72], {3{24'hfffffd}});
    endtask : t_avg

    task automatic t_vel();
        do_reset();
        accel_mode = INC_VEL;
        sample(24'h0, 24'h600000);
        take(1'b0);
        check(r[143:72], {3{24'h600000}});
        accel_mode = INT_VEL;
        sample(24'h0, 24'h600000);
        take(1'b0);
        check(r[143:72], {3{24'hc00000}});
        sample(24'h0, 24'h400000);
        take(1'b0);
        check(r[143:72], {3{24'h000000}});
    endtask : t_vel

    task automatic t_pps();
        pps_mode = PPS_SINCE_HIGH;
        pps_level = 1'b1;
        repeat (800) @(negedge clk_sys);
        take(1'b0);
        check(r[71:48], 24'h000003);
        pps_mode = PPS_SINCE_LOW;
        pps_level = 1'b0;
        repeat (10) @(negedge clk_sys);
        take(1'b0);
        check(r[71:48], 24'h000000);
        pps_mode = pps_mode_type'(2'b11);
        take(1'b0);
        check(r[71:48], 24'h000000);
        pps_mode = PPS_FILTERED;
    endtask : t_pps

    task automatic t_fifo();
        sink.got.delete();
        hold = 1'b1;
        tx_request = 1'b1;
        repeat (17) @(negedge clk_sys);
        tx_request = 1'b0;
        check(tx_ready, 1'b0);
        hold = 1'b0;
        repeat (30) @(negedge clk_sys);
        check(sink.got.size(), 16);
        check(rec_valid, 1'b0);
    endtask : t_fifo

    initial begin
        do_reset();
        t_acc();
        t_avg();
        t_vel();
        t_pps();
        t_fifo();
        test_done();
    end

    initial begin
        #40000;
        bad_count++;
        test_done();
    end
endmodule : imu_output_word_formatter_test
